// ==== ompc_checker.sv ====
// port level assertions for the operating mode power controller
module ompc_checker
    import ompc_pkg::*;
(
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       powerKey_n,
    input wire logic       terminalReady,
    input wire logic       funLevelWrite,
    input wire logic [2:0] funLevelValue,
    input wire logic       rfCommandRequest,
    input wire logic       periodicUpdateExpired,
    input wire logic       rfEnable,
    input wire logic       simEnable,
    input wire logic       softwareActive,
    input wire logic       serialAccessible,
    input wire logic       rfCommandReject,
    input wire logic       funLevelReject,
    input wire logic [2:0] funLevel,
    input wire logic       airplaneActive,
    input wire logic [2:0] opState
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // level writes only count while active
    AST_FUN_TAKE: assert property (
        funLevelWrite && opState == 3'h0 && funLevelValue inside {3'h0, 3'h1, 3'h4}
        |=> funLevel == $past(funLevelValue) && !funLevelReject)
        else $error("legal level write not taken");
    AST_FUN_BOUNCE: assert property (
        funLevelWrite && opState == 3'h0 && !(funLevelValue inside {3'h0, 3'h1, 3'h4})
        |=> funLevelReject && $stable(funLevel))
        else $error("illegal level write not refused");
    AST_MIN_LEVEL: assert property (funLevel == 3'h0 |-> !rfEnable && !simEnable)
        else $error("minimum level left radio or card on");
    AST_AIRPLANE_RF: assert property (airplaneActive |-> !rfEnable)
        else $error("radio on in airplane mode");
    AST_RF_REFUSE: assert property (rfCommandRequest && airplaneActive |=> rfCommandReject)
        else $error("radio command not refused in airplane mode");
    AST_OFF_QUIET: assert property (opState == 3'h3 |-> !softwareActive && !serialAccessible)
        else $error("software or serial alive in power off");
    // the pin crosses two flops, so allow a few cycles
    AST_KEY_WAKE: assert property (
        $fell(powerKey_n) && opState == 3'h2 |-> ##[1:5] opState != 3'h2)
        else $error("power key did not wake");
    AST_TIMER_WAKE: assert property (
        periodicUpdateExpired && opState == 3'h2 |-> ##[1:2] opState != 3'h2)
        else $error("timer expiry did not wake");
    AST_DTR_WAKE: assert property (
        (opState == 3'h1 && !terminalReady) [*4] |=> opState != 3'h1)
        else $error("terminal ready low did not end sleep");
endmodule

bind operating_mode_power_controller ompc_checker ompc_checker_inst (.*);

// ==== ompc_host_model.sv ====
// host processor model on the sleep handshake pins
module ompc_host_model (
    input  wire logic clock,
    input  wire logic hostRingIndicator,
    input  wire logic goSleep,
    output logic      terminalReady,
    output logic      hostSleepSense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic asleep_q = 1'b0;
    // a ring always wakes the host, whatever it was told; sampled on the
    // rising edge so the falling-edge goSleep from the bench never races
    always @(posedge clock) begin
        asleep_q <= goSleep && !hostRingIndicator;
    end
    // asleep host lets the module sleep; awake host pulls it out
    assign terminalReady  = asleep_q;
    assign hostSleepSense = !asleep_q;
endmodule

// ==== ompc_pkg.sv ====
// shared constants and types for the operating mode power controller
package ompc_pkg;
    // functionality level encodings
    localparam logic [2:0] OMPC_FUN_MIN      = 3'h0;
    localparam logic [2:0] OMPC_FUN_FULL     = 3'h1;
    localparam logic [2:0] OMPC_FUN_AIRPLANE = 3'h4;
    localparam logic [2:0] OMPC_FUN_RESET    = OMPC_FUN_FULL;
    // synchroniser depth
    localparam int OMPC_SYNC_STAGES = 2;
    // operating states
    typedef enum logic [2:0] {
        OMPC_ST_ACTIVE,
        OMPC_ST_SLEEP,
        OMPC_ST_SAVING,
        OMPC_ST_OFF
    } ompc_state_t;
endpackage

// ==== ompc_sync.sv ====
// two-flop synchroniser for one asynchronous level
module ompc_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      syncOut
);
    // ---------------------------------------------------------------
    // two stages
    // ---------------------------------------------------------------
    typedef struct packed {
        logic meta;
        logic stable;
    } ompc_sync_t;

    ompc_sync_t state_q;
    ompc_sync_t state_d;

    // first stage feeds only the second
    always_comb begin
        state_d        = state_q;
        state_d.meta   = asyncIn;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= '{meta: RESET_VALUE, stable: RESET_VALUE};
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stable;
endmodule

// ==== operating_mode_power_controller.sv ====
// operating mode power controller: functionality levels, sleep, saving state
// Operation
// - low airplane request with pin control enabled forces airplane mode, RF off.
// - undriven airplane request is seen high, inactive.
// - pin control of airplane mode is off after reset until configured.
// - functionality level accepts only 0, 1 and 4.
// - level 0 disables SIM interface and RF, supply stays on.
// - functionality level is 1 after reset.
// - in airplane mode, RF dependent commands are rejected.
// - level changes never touch the positioning receiver enable.
// - rising edge on wake trigger leaves deep saving state.
// - low power key wakes device from deep saving state.
// - periodic update timer expiry wakes from deep saving state.
// - saving state keeps registration; host requests are deferred.
// - deep saving state usable only once network allocated active time.
// - without idle reception parameters, regular discontinuous reception is used.
// - extended idle reception needs enable value 1 and network support.
// - sleep entered only with sleep enable set and terminal-ready high.
// - terminal-ready low makes the device leave sleep.
// - pending unsolicited report drives the ring indicator to wake host.
// - host-sleep sense monitored with selectable active polarity.
// - during sleep, paging, messages and packet data reception stay on.
// - in power off, software is halted and serial interfaces are closed.
// - wake trigger responds to rising edges; undriven it reads low.
module operating_mode_power_controller
    import ompc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    // host pins, asynchronous
    input  wire logic       airplaneRequest_n,
    input  wire logic       psmWakeTrigger,
    input  wire logic       powerKey_n,
    input  wire logic       terminalReady,
    input  wire logic       hostSleepSense,
    // command side, same clock
    input  wire logic       funLevelWrite,
    input  wire logic [2:0] funLevelValue,
    input  wire logic       airplanePinCtrlWrite,
    input  wire logic       airplanePinCtrlValue,
    input  wire logic       sleepEnableWrite,
    input  wire logic       sleepEnableValue,
    input  wire logic       savingEnableWrite,
    input  wire logic       savingEnableValue,
    input  wire logic       idleRxEnableWrite,
    input  wire logic       idleRxEnableValue,
    input  wire logic       sleepSensePolWrite,
    input  wire logic       sleepSensePolValue,
    input  wire logic       rfCommandRequest,
    // network and software side, same clock
    input  wire logic       activeTimeAllocated,
    input  wire logic       idleRxParamsReceived,
    input  wire logic       savingEntryRequest,
    input  wire logic       periodicUpdateExpired,
    input  wire logic       powerOffRequest,
    input  wire logic       powerOnRequest,
    input  wire logic       unsolicitedReportPending,
    input  wire logic       gnssEnableIn,
    // outputs
    output logic            rfEnable,
    output logic            simEnable,
    output logic            gnssEnable,
    output logic            softwareActive,
    output logic            serialAccessible,
    output logic            networkReceiveOn,
    output logic            hostRequestReady,
    output logic            attachActiveTimeRequest,
    output logic            extendedIdleReception,
    output logic            regularDrx,
    output logic            hostRingIndicator,
    output logic            hostAsleep,
    output logic            rfCommandAccept,
    output logic            rfCommandReject,
    output logic            funLevelReject,
    output logic [2:0]      funLevel,
    output logic            airplaneActive,
    output logic [2:0]      opState
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic airplaneSync_n;
    logic wakeTrigSync;
    logic powerKeySync_n;
    logic termReadySync;
    logic hostSenseSync;

    // reset values mirror the pin pulls so nothing fires on release
    // sense has no pull of its own, so low is taken as its idle level
    ompc_sync #(.RESET_VALUE(1'b1)) uAirplane (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (airplaneRequest_n),
        .syncOut (airplaneSync_n)
    );
    ompc_sync #(.RESET_VALUE(1'b0)) uWakeTrig (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (psmWakeTrigger),
        .syncOut (wakeTrigSync)
    );
    ompc_sync #(.RESET_VALUE(1'b1)) uPowerKey (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (powerKey_n),
        .syncOut (powerKeySync_n)
    );
    ompc_sync #(.RESET_VALUE(1'b0)) uTermReady (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (terminalReady),
        .syncOut (termReadySync)
    );
    ompc_sync #(.RESET_VALUE(1'b0)) uHostSense (
        .clock   (clock),
        .reset   (reset),
        .asyncIn (hostSleepSense),
        .syncOut (hostSenseSync)
    );

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    // one record, so the whole controller registers in one place and
    // reset covers every bit of it
    typedef struct packed {
        ompc_state_t mode;
        logic [2:0]  level;
        logic        pinCtrl;
        logic        sleepEn;
        logic        savingEn;
        logic        idleRxEn;
        logic        sensePol;
        logic        activeTime;
        logic        idleRxOk;
        logic        wakePrev;
        logic        rfAccept;
        logic        rfReject;
        logic        levelReject;
        logic        ring;
    } ompc_ctrl_t;

    ompc_ctrl_t ctrl_q;
    ompc_ctrl_t ctrl_d;

    logic levelLegal;
    logic pinAirplane;
    logic rfAllowed;
    logic wakeEdge;
    logic savingWake;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        // hold everything unless a command or event below moves it
        ctrl_d      = ctrl_q;
        levelLegal  = (funLevelValue == OMPC_FUN_MIN) ||
                      (funLevelValue == OMPC_FUN_FULL) ||
                      (funLevelValue == OMPC_FUN_AIRPLANE);
        pinAirplane = ctrl_q.pinCtrl && !airplaneSync_n;
        rfAllowed   = (ctrl_q.level == OMPC_FUN_FULL) && !pinAirplane;
        wakeEdge    = wakeTrigSync && !ctrl_q.wakePrev;
        savingWake  = wakeEdge || !powerKeySync_n || periodicUpdateExpired;

        // the edge is taken after the synchroniser, so a slow or bouncing
        // pin edge still gives one clean wake request per rise
        ctrl_d.wakePrev    = wakeTrigSync;
        ctrl_d.rfAccept    = 1'b0;
        ctrl_d.rfReject    = 1'b0;
        ctrl_d.levelReject = 1'b0;

        // configuration commands, taken only in active; ignored in sleep, saving and power off
        // a write outside active is dropped, not queued; the host retries
        if (ctrl_q.mode == OMPC_ST_ACTIVE) begin
            if (funLevelWrite) begin
                if (levelLegal) begin
                    ctrl_d.level = funLevelValue;
                end else begin
                    ctrl_d.levelReject = 1'b1;
                end
            end
            if (airplanePinCtrlWrite) begin
                ctrl_d.pinCtrl = airplanePinCtrlValue;
            end
            if (sleepEnableWrite) begin
                ctrl_d.sleepEn = sleepEnableValue;
            end
            if (savingEnableWrite) begin
                ctrl_d.savingEn = savingEnableValue;
            end
            if (idleRxEnableWrite) begin
                ctrl_d.idleRxEn = idleRxEnableValue;
            end
            if (sleepSensePolWrite) begin
                ctrl_d.sensePol = sleepSensePolValue;
            end
            // refusal is a pulse, so a retried command is answered again
            // airplane or minimum level refuses radio work
            if (rfCommandRequest) begin
                ctrl_d.rfAccept = rfAllowed;
                ctrl_d.rfReject = !rfAllowed;
            end
        end

        // network negotiation results, registered from the inputs every cycle
        ctrl_d.activeTime = activeTimeAllocated;
        ctrl_d.idleRxOk   = idleRxParamsReceived;

        // ring follows pending reports while software runs
        // limitation: a report raised in power off rings the host only after power on, if still pending
        ctrl_d.ring = unsolicitedReportPending &&
                      (ctrl_q.mode != OMPC_ST_OFF);

        // ---------------------------------------------------------------
        // operating mode
        // ---------------------------------------------------------------
        // power off outranks every other request in active and sleep; saving is only taken
        // once the network granted active time, otherwise the device
        // could not be reached again before the next periodic update
        // sleep leaves as soon as terminal-ready drops or sleep is disabled
        case (ctrl_q.mode)
            OMPC_ST_ACTIVE: begin
                if (powerOffRequest) begin
                    ctrl_d.mode = OMPC_ST_OFF;
                end else if (savingEntryRequest && ctrl_q.savingEn &&
                             ctrl_q.activeTime) begin
                    ctrl_d.mode = OMPC_ST_SAVING;
                end else if (ctrl_q.sleepEn && termReadySync) begin
                    ctrl_d.mode = OMPC_ST_SLEEP;
                end
            end
            OMPC_ST_SLEEP: begin
                if (powerOffRequest) begin
                    ctrl_d.mode = OMPC_ST_OFF;
                end else if (!termReadySync || !ctrl_q.sleepEn) begin
                    ctrl_d.mode = OMPC_ST_ACTIVE;
                end
            end
            OMPC_ST_SAVING: begin
                if (savingWake) begin
                    ctrl_d.mode = OMPC_ST_ACTIVE;
                end
            end
            OMPC_ST_OFF: begin
                if (powerOnRequest) begin
                    ctrl_d.mode = OMPC_ST_ACTIVE;
                end
            end
            default: begin
                ctrl_d.mode = OMPC_ST_ACTIVE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // register
    // ---------------------------------------------------------------
    // reset brings full level, active mode and every option cleared,
    // so pin control of airplane mode waits for an explicit enable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= '{mode:        OMPC_ST_ACTIVE,
                        level:       OMPC_FUN_RESET,
                        pinCtrl:     1'b0,
                        sleepEn:     1'b0,
                        savingEn:    1'b0,
                        idleRxEn:    1'b0,
                        sensePol:    1'b0,
                        activeTime:  1'b0,
                        idleRxOk:    1'b0,
                        wakePrev:    1'b0,
                        rfAccept:    1'b0,
                        rfReject:    1'b0,
                        levelReject: 1'b0,
                        ring:        1'b0};
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ---------------------------------------------------------------
    // shared output terms
    // ---------------------------------------------------------------
    logic running;
    logic radioUp;

    // saving and off stop the radio; sleep keeps network reception
    // the synced pin is used directly, so the radio drops as soon as
    // the request has crossed the synchroniser, with no extra register
    assign running  = (ctrl_q.mode == OMPC_ST_ACTIVE) || (ctrl_q.mode == OMPC_ST_SLEEP);
    assign radioUp  = running && (ctrl_q.level == OMPC_FUN_FULL) &&
                      !(ctrl_q.pinCtrl && !airplaneSync_n);

    // ---------------------------------------------------------------
    // supply domain enables
    // ---------------------------------------------------------------
    // positioning follows its own enable and only power off cuts it
    assign rfEnable         = radioUp;
    assign simEnable        = running && (ctrl_q.level != OMPC_FUN_MIN);
    assign gnssEnable       = gnssEnableIn && (ctrl_q.mode != OMPC_ST_OFF);
    assign softwareActive   = ctrl_q.mode != OMPC_ST_OFF;
    assign serialAccessible = running;

    // ---------------------------------------------------------------
    // reception mode and host readiness
    // ---------------------------------------------------------------
    // extended idle needs the host enable, the network grant and a live
    // radio; with the radio up, anything short of that falls back to the regular cycle
    assign networkReceiveOn = radioUp;
    assign hostRequestReady = ctrl_q.mode == OMPC_ST_ACTIVE;
    assign attachActiveTimeRequest = ctrl_q.savingEn;
    assign extendedIdleReception = ctrl_q.idleRxEn && ctrl_q.idleRxOk && radioUp;
    assign regularDrx       = radioUp && !extendedIdleReception;

    // ---------------------------------------------------------------
    // host handshake
    // ---------------------------------------------------------------
    // ring is registered, so it cannot glitch while reports settle
    assign hostRingIndicator = ctrl_q.ring;
    assign hostAsleep       = hostSenseSync == ctrl_q.sensePol;

    // ---------------------------------------------------------------
    // command answers and status
    // ---------------------------------------------------------------
    // answers are one-cycle pulses, one per strobe taken in active
    assign rfCommandAccept  = ctrl_q.rfAccept;
    assign rfCommandReject  = ctrl_q.rfReject;
    assign funLevelReject   = ctrl_q.levelReject;
    assign funLevel         = ctrl_q.level;
    assign airplaneActive   = (ctrl_q.level == OMPC_FUN_AIRPLANE) ||
                              (ctrl_q.pinCtrl && !airplaneSync_n);
    assign opState          = ctrl_q.mode;
endmodule

// ==== operating_mode_power_controller_tb_top.sv ====
// self-checking bench for the operating mode power controller
module operating_mode_power_controller_tb_top
    import ompc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset = 1'b1, goSleep = 1'b0;
    logic airplaneRequest_n = 1'b1, powerKey_n = 1'b1, psmWakeTrigger = 1'b0;
    logic funLevelWrite = 1'b0, airplanePinCtrlWrite = 1'b0, airplanePinCtrlValue = 1'b0;
    logic sleepEnableWrite = 1'b0, sleepEnableValue = 1'b0, savingEnableWrite = 1'b0;
    logic savingEnableValue = 1'b0, idleRxEnableWrite = 1'b0, idleRxEnableValue = 1'b0;
    logic sleepSensePolWrite = 1'b0, sleepSensePolValue = 1'b0, rfCommandRequest = 1'b0;
    logic activeTimeAllocated = 1'b0, idleRxParamsReceived = 1'b0, savingEntryRequest = 1'b0;
    logic periodicUpdateExpired = 1'b0, powerOffRequest = 1'b0, powerOnRequest = 1'b0;
    logic unsolicitedReportPending = 1'b0, gnssEnableIn = 1'b0;
    logic [2:0] funLevelValue = 3'h1, lvl = 3'h1, funLevel, opState;
    logic rfEnable, simEnable, gnssEnable, softwareActive, serialAccessible, networkReceiveOn;
    logic hostRequestReady, attachActiveTimeRequest, extendedIdleReception, regularDrx;
    logic hostRingIndicator, hostAsleep, rfCommandAccept, rfCommandReject, funLevelReject;
    logic airplaneActive;
    wire logic terminalReady, hostSleepSense;
    int errors = 0, samples_checked = 0, cycles = 0;

    operating_mode_power_controller operating_mode_power_controller_inst (.*);
    ompc_host_model ompc_host_model_inst (.*);

    always #5 clock = ~clock;
    // hang guard, far above the hundred-odd cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one-cycle strobe, raised and dropped on falling edges
    task automatic pulse(ref logic w);
        w = 1'b1;
        tick(1);
        w = 1'b0;
    endtask

    // pins cross a synchroniser, so poll with a bound
    task automatic waitState(input logic [2:0] v);
        for (int i = 0; i < 12 && opState !== v; i++) tick(1);
        check("state", v, opState);
    endtask

    initial begin
        tick(20);
        reset = 1'b0;
        tick(1);
        check("level", 3'h1, funLevel);
        check("sim", 3'h1, simEnable);
        airplaneRequest_n = 1'b0;
        tick(5);
        check("airplane", 3'h0, airplaneActive);
        airplanePinCtrlValue = 1'b1;
        pulse(airplanePinCtrlWrite);
        tick(4);
        check("airplane", 3'h1, airplaneActive);
        pulse(rfCommandRequest);
        check("rfReject", 3'h1, rfCommandReject);
        airplaneRequest_n = 1'b1;
        tick(5);
        pulse(rfCommandRequest);
        check("rfAccept", 3'h1, rfCommandAccept);
        $display("airplane test done");
        gnssEnableIn = 1'b1;
        for (int v = 7; v >= 0; v--) begin
            funLevelValue = 3'(v);
            pulse(funLevelWrite);
            if (v inside {0, 1, 4}) lvl = 3'(v);
            check("level", lvl, funLevel);
            check("levelReject", {2'h0, !(v inside {0, 1, 4})}, funLevelReject);
            check("rf", {2'h0, lvl == 3'h1}, rfEnable);
            check("sim", {2'h0, lvl != 3'h0}, simEnable);
            check("gnss", 3'h1, gnssEnable);
            tick(1);
        end
        funLevelValue = 3'h1;
        pulse(funLevelWrite);
        $display("level test done");
        goSleep = 1'b1;
        tick(6);
        check("state", 3'h0, opState);
        check("hostAsleep", 3'h1, hostAsleep);
        sleepSensePolValue = 1'b1;
        pulse(sleepSensePolWrite);
        check("hostAsleep", 3'h0, hostAsleep);
        sleepEnableValue = 1'b1;
        pulse(sleepEnableWrite);
        waitState(3'h1);
        check("netRx", 3'h1, networkReceiveOn);
        unsolicitedReportPending = 1'b1;
        waitState(3'h0);
        check("ring", 3'h1, hostRingIndicator);
        check("hostAsleep", 3'h1, hostAsleep);
        unsolicitedReportPending = 1'b0;
        goSleep = 1'b0;
        $display("sleep test done");
        idleRxParamsReceived = 1'b1;
        tick(3);
        check("idleRx", 3'h0, extendedIdleReception);
        idleRxEnableValue = 1'b1;
        pulse(idleRxEnableWrite);
        tick(2);
        check("idleRx", 3'h1, extendedIdleReception);
        idleRxParamsReceived = 1'b0;
        tick(3);
        check("regularDrx", 3'h1, regularDrx);
        $display("idle reception test done");
        savingEnableValue = 1'b1;
        pulse(savingEnableWrite);
        check("activeTimeReq", 3'h1, attachActiveTimeRequest);
        savingEntryRequest = 1'b1;
        tick(4);
        check("state", 3'h0, opState);
        activeTimeAllocated = 1'b1;
        // each pass wakes by a different source
        for (int m = 0; m < 3; m++) begin
            savingEntryRequest = 1'b1;
            waitState(3'h2);
            savingEntryRequest = 1'b0;
            check("hostReady", 3'h0, hostRequestReady);
            tick(3);
            if (m == 0) psmWakeTrigger = 1'b1;
            if (m == 1) powerKey_n = 1'b0;
            if (m == 2) pulse(periodicUpdateExpired);
            waitState(3'h0);
            check("hostReady", 3'h1, hostRequestReady);
            psmWakeTrigger = 1'b0;
            powerKey_n = 1'b1;
            tick(4);
        end
        $display("saving test done");
        pulse(powerOffRequest);
        waitState(3'h3);
        check("software", 3'h0, softwareActive);
        check("serial", 3'h0, serialAccessible);
        pulse(powerOnRequest);
        waitState(3'h0);
        $display("power off test done");
        conclude();
    end
endmodule
